// >>> rtl/lsec_cfg.svh
// constants for the line signal element codec: offsets, timing counts, codes
`ifndef LSEC_CFG_SVH
`define LSEC_CFG_SVH

// ----------------------------------------------------------------------
// clock and line frame timing
// ----------------------------------------------------------------------
`define LSEC_CLK_HZ 25000000
`define LSEC_FRAME_US 1000
`define LSEC_FRAME_CYC (`LSEC_CLK_HZ / 1000000 * `LSEC_FRAME_US)
`define LSEC_FRAME_CYC_MAX 65535

// ----------------------------------------------------------------------
// line frame layout, in ternary symbols
// ----------------------------------------------------------------------
`define LSEC_SYMS 7'h78
`define LSEC_LAST_SYM 7'h77
`define LSEC_SYNC_LEN 7'h0b
`define LSEC_SYNC_TOP 4'ha
`define LSEC_BARKER 11'h712

// ----------------------------------------------------------------------
// awake tone: blocks of eight plus symbols, sixteen tone periods
// ----------------------------------------------------------------------
`define LSEC_TONE_BLK 4'h8
`define LSEC_TONE_LEN 9'h100

// ----------------------------------------------------------------------
// detection thresholds
// ----------------------------------------------------------------------
`define LSEC_DET_FRAMES 4'h8
`define LSEC_TREQ_ONES 5'h10

// ----------------------------------------------------------------------
// scrambler polynomial: length and the two inner taps
// ----------------------------------------------------------------------
`define LSEC_SCR_LEN 23
`define LSEC_TAP_A 5
`define LSEC_TAP_B 18

// ----------------------------------------------------------------------
// control/indicate codes
// ----------------------------------------------------------------------
`define LSEC_CI_LINK_SYNC 4'h7
`define LSEC_CI_NONE 4'h0

`endif

// >>> rtl/lsec_pkg.sv
// types shared by the line signal element codec modules
package lsec_pkg;

   // transmitted signal element, gray along the activation path
   typedef enum logic [2:0] {
      LSEC_E_SILENCE = 3'h0,
      LSEC_E_AWAKE = 3'h1,
      LSEC_E_UNFRAMED_ZERO = 3'h3,
      LSEC_E_FRAMED_ZERO = 3'h2,
      LSEC_E_FRAMED_ONES = 3'h6,
      LSEC_E_TREQ = 3'h7,
      LSEC_E_PAYLOAD = 3'h5,
      LSEC_E_SINGLE_PULSE = 3'h4
   } lsec_elem_t;

   // ternary line symbol
   typedef enum logic [1:0] {
      LSEC_T_ZERO = 2'h0,
      LSEC_T_PLUS = 2'h1,
      LSEC_T_MINUS = 2'h3
   } lsec_tern_t;

   // exchange-side step after the far end reports full sync
   typedef enum logic [1:0] {
      LSEC_S_IDLE = 2'h0,
      LSEC_S_TREQ = 2'h1,
      LSEC_S_DATA = 2'h3
   } lsec_step_t;

endpackage : lsec_pkg

// >>> rtl/lsec_scr_if.sv
// bundle between the codec and its scrambler instances
`timescale 1ns/1ns
`default_nettype none

interface lsec_scr_if #(parameter int W = 1) ();
   logic en;
   logic alt_poly;
   logic [W-1:0] din;
   logic [W-1:0] dout;

   modport core (input en, input alt_poly, input din, output dout);
   modport user (output en, output alt_poly, output din, input dout);
endinterface : lsec_scr_if

`default_nettype wire

// >>> rtl/lsec_scrambler.sv
// self-synchronising scrambler or descrambler, W bits per enable, msb first
`timescale 1ns/1ns
`default_nettype none
`include "lsec_cfg.svh"

module lsec_scrambler #(
   parameter int W = 1,
   parameter bit DESCR = 1'b0
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // data
   lsec_scr_if.core bus
);

   if (W < 1 || W > 8) begin : g_chk
      $error("lsec_scrambler: W must be 1 to 8");
   end

   localparam int LEN = `LSEC_SCR_LEN;
   localparam int TA = `LSEC_TAP_A - 1;
   localparam int TB = `LSEC_TAP_B - 1;

   logic [LEN-1:0] sr_r;
   logic [LEN-1:0] sr_nxt;
   logic [W-1:0] out_w;

   // delayed terms z^-tap and z^-23; the descrambler shifts in line bits
   always_comb begin
      logic fb;
      logic o;
      fb = 1'b0;
      o = 1'b0;
      sr_nxt = sr_r;
      out_w = '0;
      for (int i = W - 1; i >= 0; i--) begin
         fb = (bus.alt_poly ? sr_nxt[TB] : sr_nxt[TA]) ^ sr_nxt[LEN-1];
         o = bus.din[i] ^ fb;
         out_w[i] = o;
         sr_nxt = {sr_nxt[LEN-2:0], (DESCR ? bus.din[i] : o)};
      end
   end

   assign bus.dout = out_w;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sr_r <= '0;
      end else if (bus.en) begin
         sr_r <= sr_nxt;
      end
   end

endmodule : lsec_scrambler

`default_nettype wire

// >>> rtl/lsec_codec.sv
// line signal element generator and detector for the ternary subscriber line
`timescale 1ns/1ns
`default_nettype none
`include "lsec_cfg.svh"

// Notes on behaviour
// - awake tone: eight plus symbols, sixteen times
// - unframed zero: scrambled zeros, zero sync slot
// - framed zero with sync word, NT once synced
// - NT framed ones reports full link sync
// - transparent request: framed ones for 1 ms
// - payload: interface data, framed with sync
// - silence: continuous ternary zero, no frame
// - LT: zeros or ones eight clean frames detected
// - NT sees sixteen ones: transparent request
// - LT sees one all-zero frame: silence
// - LT sends framed zero; NT syncs on it
// - unsynced NT sends unframed zero only
// - LT framed zero detect gives link sync
// - LT answers framed ones with transparent request
// - NT on request: payload, transparent indication
// - maintenance slot: loop commands or error marks
// - single pulse test: one pulse per ms
// - scrambler polynomial by mode and loop
module lsec_codec #(
   parameter int FRAME_CYC = `LSEC_FRAME_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // configuration
   input wire logic lt_mode,
   input wire logic loop_closed,
   // element command and side channels
   input wire lsec_pkg::lsec_elem_t elem_cmd,
   input wire lsec_pkg::lsec_tern_t loop_sym,
   input wire logic code_err,
   // payload from the digital interface
   input wire logic [3:0] tx_data,
   output logic tx_data_take,
   // toward the ternary coder
   output logic tx_sym_en,
   output logic tx_frame_start,
   output logic tx_direct,
   output lsec_pkg::lsec_tern_t tx_sym,
   output logic tx_nibble_en,
   output logic [3:0] tx_nibble,
   output lsec_pkg::lsec_elem_t tx_elem,
   // from the receiver
   input wire logic rx_frame_start,
   input wire logic rx_locked,
   input wire logic rx_sym_en,
   input wire lsec_pkg::lsec_tern_t rx_sym,
   input wire logic rx_bit_en,
   input wire logic rx_bit,
   // status
   output logic det_framed_zero,
   output logic det_framed_ones,
   output logic det_treq,
   output logic det_silence,
   output logic transparent_ind,
   output logic [3:0] ci_ind,
   output logic ci_ind_valid
);
   import lsec_pkg::*;

   if (FRAME_CYC < 120 || FRAME_CYC > `LSEC_FRAME_CYC_MAX) begin : g_chk
      $error("lsec_codec: FRAME_CYC out of range");
   end

   // ----------------------------------------------------------------------
   // symbol timing: exact 120 symbols per frame by a fractional accumulator
   // ----------------------------------------------------------------------
   logic [15:0] acc_r;
   logic [6:0] sym_idx_r;
   logic [1:0] ph_r;

   wire logic [16:0] acc_sum = {1'b0, acc_r} + {10'h000, `LSEC_SYMS};
   wire logic [16:0] frame_cyc_w = 17'(FRAME_CYC);
   wire logic sym_tick = acc_sum >= frame_cyc_w;
   wire logic [16:0] acc_wrap = acc_sum - frame_cyc_w;
   wire logic last_sym = sym_idx_r == `LSEC_LAST_SYM;
   wire logic frame_end = sym_tick && last_sym;
   wire logic sync_slot = sym_idx_r < `LSEC_SYNC_LEN;
   wire logic m_slot = last_sym;
   wire logic data_slot = !sync_slot && !m_slot;
   wire logic nib_slot = data_slot && (ph_r == 2'h0);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         acc_r <= 16'h0000;
         sym_idx_r <= 7'h00;
         ph_r <= 2'h0;
      end else begin
         acc_r <= sym_tick ? acc_wrap[15:0] : acc_sum[15:0];
         if (sym_tick) begin
            sym_idx_r <= last_sym ? 7'h00 : sym_idx_r + 7'h01;
            ph_r <= (!data_slot || ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // element selection, switched only on frame boundaries
   // ----------------------------------------------------------------------
   lsec_elem_t elem_r;
   lsec_elem_t elem_nxt;
   lsec_step_t step_r;
   lsec_step_t step_nxt;
   logic transp_r;
   logic transp_nxt;
   logic det_zero_r;
   logic det_ones_r;
   logic det_treq_r;
   logic det_sil_r;

   wire logic cmd_framed = elem_cmd == LSEC_E_FRAMED_ZERO || elem_cmd == LSEC_E_FRAMED_ONES
      || elem_cmd == LSEC_E_TREQ || elem_cmd == LSEC_E_PAYLOAD;
   wire logic cmd_data = elem_cmd == LSEC_E_FRAMED_ONES || elem_cmd == LSEC_E_PAYLOAD;

   always_comb begin
      elem_nxt = elem_cmd;
      step_nxt = step_r;
      transp_nxt = transp_r;
      if (lt_mode) begin
         transp_nxt = 1'b0;
         if (!cmd_framed) begin
            step_nxt = LSEC_S_IDLE;
         end else if (step_r == LSEC_S_IDLE && det_ones_r) begin
            elem_nxt = LSEC_E_TREQ;
            step_nxt = LSEC_S_TREQ;
         end else if (step_r != LSEC_S_IDLE) begin
            // request stands one whole frame, then data follows
            elem_nxt = LSEC_E_PAYLOAD;
            step_nxt = LSEC_S_DATA;
         end
      end else begin
         step_nxt = LSEC_S_IDLE;
         if (!cmd_framed) begin
            transp_nxt = 1'b0;
         end
         if (cmd_framed && !rx_locked) begin
            elem_nxt = LSEC_E_UNFRAMED_ZERO;
         end else if (cmd_data && (det_treq_r || transp_r)) begin
            elem_nxt = LSEC_E_PAYLOAD;
            transp_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         elem_r <= LSEC_E_SILENCE;
         step_r <= LSEC_S_IDLE;
         transp_r <= 1'b0;
      end else if (frame_end) begin
         elem_r <= elem_nxt;
         step_r <= step_nxt;
         transp_r <= transp_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // transmit symbol composition
   // ----------------------------------------------------------------------
   logic [8:0] tone_cnt_r;
   logic cv_pend_r;

   wire logic coded_elem = elem_r == LSEC_E_UNFRAMED_ZERO || elem_r == LSEC_E_FRAMED_ZERO
      || elem_r == LSEC_E_FRAMED_ONES || elem_r == LSEC_E_TREQ || elem_r == LSEC_E_PAYLOAD;
   wire logic framed_elem = coded_elem && elem_r != LSEC_E_UNFRAMED_ZERO;
   wire logic tone_on = tone_cnt_r < `LSEC_TONE_LEN && tone_cnt_r[3:0] < `LSEC_TONE_BLK;
   wire logic [10:0] barker_w = `LSEC_BARKER;
   wire logic [3:0] bk_idx = `LSEC_SYNC_TOP - sym_idx_r[3:0];
   wire lsec_tern_t barker_sym = barker_w[bk_idx] ? LSEC_T_PLUS : LSEC_T_MINUS;
   // loop commands go downstream, error marks upstream
   wire lsec_tern_t maint_sym = lt_mode ? loop_sym
      : (cv_pend_r ? LSEC_T_PLUS : LSEC_T_ZERO);
   wire logic ones_elem = elem_r == LSEC_E_FRAMED_ONES || elem_r == LSEC_E_TREQ;
   wire logic [3:0] tx_src = (elem_r == LSEC_E_PAYLOAD) ? tx_data
      : (ones_elem ? 4'hf : 4'h0);
   wire logic tx_scr_en = sym_tick && nib_slot && coded_elem;
   wire logic m_sent = sym_tick && m_slot && framed_elem && !lt_mode;

   lsec_tern_t sym_sel;
   logic direct_sel;

   always_comb begin
      sym_sel = LSEC_T_ZERO;
      direct_sel = 1'b1;
      case (elem_r)
         LSEC_E_SILENCE: begin
            sym_sel = LSEC_T_ZERO;
         end
         LSEC_E_AWAKE: begin
            if (tone_on) begin
               sym_sel = LSEC_T_PLUS;
            end
         end
         LSEC_E_SINGLE_PULSE: begin
            if (sym_idx_r == 7'h00) begin
               sym_sel = LSEC_T_PLUS;
            end
         end
         default: begin
            if (sync_slot) begin
               if (framed_elem) begin
                  sym_sel = barker_sym;
               end
            end else if (m_slot) begin
               if (framed_elem) begin
                  sym_sel = maint_sym;
               end
            end else begin
               direct_sel = 1'b0;
            end
         end
      endcase
   end

   // tx scrambler: closed-loop polynomial except an open-loop NT
   lsec_scr_if #(.W(4)) tx_scr ();
   assign tx_scr.en = tx_scr_en;
   assign tx_scr.din = tx_src;
   assign tx_scr.alt_poly = !lt_mode && !loop_closed;

   lsec_scrambler #(.W(4), .DESCR(1'b0)) u_tx_scr (
      .ref_clk(ref_clk),
      .rst(rst),
      .bus(tx_scr.core)
   );

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tone_cnt_r <= 9'h000;
         cv_pend_r <= 1'b0;
      end else begin
         if (elem_r != LSEC_E_AWAKE) begin
            tone_cnt_r <= 9'h000;
         end else if (sym_tick && tone_cnt_r < `LSEC_TONE_LEN) begin
            tone_cnt_r <= tone_cnt_r + 9'h001;
         end
         // a new error in the sending cycle is kept for the next frame
         cv_pend_r <= code_err || (cv_pend_r && !m_sent);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_sym_en <= 1'b0;
         tx_frame_start <= 1'b0;
         tx_direct <= 1'b1;
         tx_sym <= LSEC_T_ZERO;
         tx_nibble_en <= 1'b0;
         tx_nibble <= 4'h0;
         tx_data_take <= 1'b0;
         tx_elem <= LSEC_E_SILENCE;
      end else begin
         tx_sym_en <= sym_tick;
         tx_frame_start <= sym_tick && sym_idx_r == 7'h00;
         tx_nibble_en <= tx_scr_en;
         tx_data_take <= tx_scr_en && elem_r == LSEC_E_PAYLOAD;
         tx_elem <= elem_r;
         if (sym_tick) begin
            tx_sym <= sym_sel;
            tx_direct <= direct_sel;
         end
         if (tx_scr_en) begin
            tx_nibble <= tx_scr.dout;
         end
      end
   end

   // ----------------------------------------------------------------------
   // receive side: descrambler and pattern detectors
   // ----------------------------------------------------------------------
   lsec_scr_if #(.W(1)) rx_scr ();
   assign rx_scr.en = rx_bit_en;
   assign rx_scr.din = rx_bit;
   assign rx_scr.alt_poly = lt_mode && !loop_closed;

   lsec_scrambler #(.W(1), .DESCR(1'b1)) u_rx_scr (
      .ref_clk(ref_clk),
      .rst(rst),
      .bus(rx_scr.core)
   );

   wire logic rx_dbit = rx_scr.dout[0];
   logic [1:0] run_det;

   // index 0 tracks zeros, index 1 tracks ones; a partial frame never counts
   for (genvar i = 0; i < 2; i++) begin : g_run
      logic [3:0] cnt_r;
      logic clean_r;
      wire logic dev = rx_bit_en && (rx_dbit != 1'(i));

      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            cnt_r <= 4'h0;
            clean_r <= 1'b0;
         end else if (dev) begin
            cnt_r <= 4'h0;
            clean_r <= 1'b0;
         end else if (rx_frame_start) begin
            clean_r <= 1'b1;
            if (clean_r && cnt_r < `LSEC_DET_FRAMES) begin
               cnt_r <= cnt_r + 4'h1;
            end
         end
      end

      assign run_det[i] = cnt_r >= `LSEC_DET_FRAMES;
   end

   logic [4:0] ones_run_r;
   logic sil_clean_r;
   logic sync_r;

   wire logic sil_dirty = rx_sym_en && rx_sym != LSEC_T_ZERO;
   wire logic sync_nxt = lt_mode && (det_zero_r || (sync_r && !det_sil_r));

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ones_run_r <= 5'h00;
         sil_clean_r <= 1'b0;
         det_sil_r <= 1'b0;
      end else begin
         if (rx_bit_en) begin
            if (!rx_dbit) begin
               ones_run_r <= 5'h00;
            end else if (ones_run_r < `LSEC_TREQ_ONES) begin
               ones_run_r <= ones_run_r + 5'h01;
            end
         end
         // a nonzero symbol on the boundary counts against both the ending frame and the new frame
         if (sil_dirty) begin
            sil_clean_r <= 1'b0;
            det_sil_r <= 1'b0;
         end else if (rx_frame_start) begin
            sil_clean_r <= 1'b1;
            det_sil_r <= lt_mode && sil_clean_r;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         det_zero_r <= 1'b0;
         det_ones_r <= 1'b0;
         det_treq_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         det_zero_r <= lt_mode && run_det[0];
         det_ones_r <= lt_mode && run_det[1];
         det_treq_r <= !lt_mode && ones_run_r >= `LSEC_TREQ_ONES;
         sync_r <= sync_nxt;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         det_framed_zero <= 1'b0;
         det_framed_ones <= 1'b0;
         det_treq <= 1'b0;
         det_silence <= 1'b0;
         transparent_ind <= 1'b0;
         ci_ind <= `LSEC_CI_NONE;
         ci_ind_valid <= 1'b0;
      end else begin
         det_framed_zero <= det_zero_r;
         det_framed_ones <= det_ones_r;
         det_treq <= det_treq_r;
         det_silence <= det_sil_r;
         transparent_ind <= transp_r;
         ci_ind <= sync_nxt ? `LSEC_CI_LINK_SYNC : `LSEC_CI_NONE;
         ci_ind_valid <= sync_nxt;
      end
   end

endmodule : lsec_codec

`default_nettype wire

// >>> tb/lsec_codec_properties.sv
// concurrent checks on the codec top-level ports
`timescale 1ns/1ns
`default_nettype none
`include "lsec_cfg.svh"

module lsec_codec_chk #(
   parameter int FRAME_CYC = 240
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // configuration
   input wire logic lt_mode,
   // transmit side
   input wire logic tx_sym_en,
   input wire logic tx_frame_start,
   input wire logic tx_direct,
   input wire lsec_pkg::lsec_tern_t tx_sym,
   input wire logic tx_nibble_en,
   input wire lsec_pkg::lsec_elem_t tx_elem,
   // status
   input wire logic det_framed_zero,
   input wire logic det_treq,
   input wire logic transparent_ind,
   input wire logic [3:0] ci_ind,
   input wire logic ci_ind_valid
);
   import lsec_pkg::*;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------------
   sequence s_zero_seen;
      $rose(det_framed_zero) && lt_mode;
   endsequence
   sequence s_sync_ind;
      ci_ind == `LSEC_CI_LINK_SYNC && ci_ind_valid;
   endsequence

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   silence_level_a: assert property (
      tx_sym_en && tx_elem == LSEC_E_SILENCE && $stable(tx_elem) |-> tx_sym == LSEC_T_ZERO)
      else $error("symbol sent during silence");
   single_pulse_a: assert property (
      tx_sym_en && !tx_frame_start && tx_elem == LSEC_E_SINGLE_PULSE && $stable(tx_elem)
      |-> tx_sym == LSEC_T_ZERO)
      else $error("extra pulse in test frame");
   unframed_slot_a: assert property (
      tx_frame_start && tx_elem == LSEC_E_UNFRAMED_ZERO |-> tx_sym == LSEC_T_ZERO)
      else $error("sync slot not zero");
   framed_head_a: assert property (
      tx_frame_start && tx_elem inside {LSEC_E_FRAMED_ZERO, LSEC_E_FRAMED_ONES,
      LSEC_E_TREQ, LSEC_E_PAYLOAD} |-> tx_sym == LSEC_T_PLUS && tx_direct)
      else $error("sync word does not open frame");
   coded_data_a: assert property (
      tx_nibble_en |-> !tx_direct && tx_sym_en)
      else $error("nibble outside coded slot");
   link_sync_a: assert property (
      s_zero_seen |-> ##[0:2] s_sync_ind)
      else $error("no link sync code");
   sync_clear_a: assert property (
      !lt_mode [*3] |-> ci_ind == `LSEC_CI_NONE)
      else $error("link sync code in NT mode");
   treq_nt_a: assert property (
      $rose(det_treq) |-> !lt_mode)
      else $error("request detected in LT mode");
   treq_lt_a: assert property (
      $rose(tx_elem == LSEC_E_TREQ) |-> lt_mode)
      else $error("request sent in NT mode");
   ones_stop_a: assert property (
      transparent_ind && tx_frame_start |-> tx_elem != LSEC_E_FRAMED_ONES)
      else $error("framed ones while transparent");
endmodule : lsec_codec_chk

bind lsec_codec lsec_codec_chk #(.FRAME_CYC(FRAME_CYC)) i_lsec_codec_chk (
   .ref_clk, .rst, .lt_mode, .tx_sym_en, .tx_frame_start, .tx_direct, .tx_sym,
   .tx_nibble_en, .tx_elem, .det_framed_zero, .det_treq, .transparent_ind,
   .ci_ind, .ci_ind_valid);

`default_nettype wire

// >>> tb/lsec_far_end.sv
// far-end line station model: frame strobes, symbols and line bits for the codec descrambler
`timescale 1ns/1ns
`default_nettype none

module lsec_far_end #(
   parameter int FC = 240
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // pattern: 0 silence, 1 zeros, 2 ones
   input wire logic [1:0] mode,
   input wire logic glitch,
   // toward the codec receive side
   output logic rx_frame_start,
   output logic rx_sym_en,
   output var lsec_pkg::lsec_tern_t rx_sym,
   output logic rx_bit_en,
   output logic rx_bit
);
   import lsec_pkg::*;
   int cnt_r;
   logic sgn_r;
   logic pat;

   // silence carries alternating bits so no zero or ones run is faked
   assign pat = (mode == 2'h2) | ((mode == 2'h0) & cnt_r[1]);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 0;
         sgn_r <= 1'b0;
         rx_frame_start <= 1'b0;
         rx_sym_en <= 1'b0;
         rx_bit_en <= 1'b0;
         rx_sym <= LSEC_T_ZERO;
         rx_bit <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == FC - 1) ? 0 : cnt_r + 1;
         sgn_r <= ~sgn_r;
         rx_frame_start <= (cnt_r == 0);
         rx_sym_en <= ~cnt_r[0];
         rx_bit_en <= ~cnt_r[0];
         rx_sym <= (mode == 2'h0) ? LSEC_T_ZERO : (sgn_r ? LSEC_T_PLUS : LSEC_T_MINUS);
         // off-strobe cycles show the inverse, never a held value
         rx_bit <= pat ^ glitch ^ cnt_r[0];
      end
   end
endmodule : lsec_far_end

`default_nettype wire

// >>> tb/test_line_signal_element_codec.sv
// self-checking bench for the line signal element codec
`timescale 1ns/1ns
`default_nettype none
`include "lsec_cfg.svh"

module test_line_signal_element_codec;
   import lsec_pkg::*;
   localparam int FC = 240;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic lt_mode = 1'b1;
   logic rx_locked = 1'b0;
   logic [3:0] tx_data = 4'h9;
   lsec_elem_t elem_cmd = LSEC_E_SILENCE;
   logic [1:0] far_mode = 2'h0;
   logic far_glitch = 1'b0;
   logic tx_data_take, tx_sym_en, tx_frame_start, tx_direct, tx_nibble_en;
   logic [3:0] tx_nibble, ci_ind;
   lsec_tern_t tx_sym, rx_sym;
   lsec_elem_t tx_elem, el;
   logic rx_frame_start, rx_sym_en, rx_bit_en, rx_bit, ci_ind_valid;
   logic det_framed_zero, det_framed_ones, det_treq, det_silence, transparent_ind;
   logic [4:0] flags;
   logic [10:0] sw;
   int np, nz, nn, n;
   int fail_count = 0;
   int total_checks = 0;

   assign flags = {transparent_ind, det_silence, det_treq, det_framed_ones, det_framed_zero};
   always #20 ref_clk = ~ref_clk;

   lsec_codec #(.FRAME_CYC(FC)) i_lsec_codec (
      .ref_clk, .rst, .lt_mode, .loop_closed(1'b0), .elem_cmd, .loop_sym(LSEC_T_PLUS),
      .code_err(1'b0), .tx_data, .tx_data_take, .tx_sym_en, .tx_frame_start, .tx_direct,
      .tx_sym, .tx_nibble_en, .tx_nibble, .tx_elem, .rx_frame_start, .rx_locked,
      .rx_sym_en, .rx_sym, .rx_bit_en, .rx_bit, .det_framed_zero, .det_framed_ones,
      .det_treq, .det_silence, .transparent_ind, .ci_ind, .ci_ind_valid);
   lsec_far_end #(.FC(FC)) i_lsec_far_end (
      .ref_clk, .rst, .mode(far_mode), .glitch(far_glitch), .rx_frame_start,
      .rx_sym_en, .rx_sym, .rx_bit_en, .rx_bit);

   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   task automatic step(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask : step

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : chk

   task automatic wait_sig(input int sel, input int lim);
      n = 0;
      while (flags[sel] !== 1'b1 && n < lim) begin
         step(1);
         n++;
      end
      if (n >= lim) begin
         chk(1'b0, "wait ran out");
         end_sim();
      end
   endtask : wait_sig

   // one whole frame: plus and nonzero direct symbols, first 11 as plus bits
   task automatic grab();
      int i;
      int ns;
      i = 0;
      ns = 0;
      np = 0;
      nz = 0;
      nn = 0;
      while (tx_frame_start !== 1'b1 && i < 2 * FC) begin
         step(1);
         i++;
      end
      if (i >= 2 * FC) begin
         chk(1'b0, "no frame start");
         end_sim();
      end
      for (i = 0; i < FC; i++) begin
         if (i == FC / 2) el = tx_elem;
         if (tx_sym_en === 1'b1 && tx_direct === 1'b1) begin
            np += (tx_sym === LSEC_T_PLUS);
            nz += (tx_sym !== LSEC_T_ZERO);
         end
         if (tx_sym_en === 1'b1 && ns < 11) begin
            sw = {sw[9:0], tx_sym === LSEC_T_PLUS};
            ns++;
         end
         nn += (tx_nibble_en === 1'b1);
         step(1);
      end
   endtask : grab

   // command lands on the frame after the one sampled here
   task automatic cmd(input lsec_elem_t e);
      elem_cmd = e;
      grab();
   endtask : cmd

   task automatic do_reset();
      rst = 1'b1;
      step(6);
      rst = 1'b0;
      step(1);
   endtask : do_reset

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_silence_pulse();
      cmd(LSEC_E_SILENCE);
      grab();
      chk(nz == 0 && el === LSEC_E_SILENCE, "line not silent");
      wait_sig(3, 3 * FC);
      chk(n <= 2 * FC + 3, "silence not seen");
      cmd(LSEC_E_SINGLE_PULSE);
      grab();
      chk(np == 1 && nz == 1 && sw[10] === 1'b1, "single pulse wrong");
      $display("test silence and pulse done");
   endtask : t_silence_pulse

   task automatic t_awake();
      int tot;
      cmd(LSEC_E_AWAKE);
      grab();
      chk(sw === 11'h7f8, "tone block shape");
      tot = np;
      repeat (3) begin
         grab();
         tot += np;
      end
      chk(tot == 16 * 8 && nz == 0, "tone length");
      $display("test awake done");
   endtask : t_awake

   task automatic t_framed();
      cmd(LSEC_E_UNFRAMED_ZERO);
      grab();
      chk(el === LSEC_E_UNFRAMED_ZERO && sw === 11'h000, "unframed zero");
      cmd(LSEC_E_FRAMED_ZERO);
      grab();
      chk(el === LSEC_E_FRAMED_ZERO && sw === `LSEC_BARKER && nn == 36, "framed zero");
      $display("test framed done");
   endtask : t_framed

   task automatic t_lt_detect();
      far_mode = 2'h1;
      step(4 * FC);
      far_glitch = 1'b1;
      step(2);
      far_glitch = 1'b0;
      wait_sig(0, 10 * FC);
      chk(n >= 8 * FC - 4, "count kept over deviation");
      chk(n <= 9 * FC + 4, "zero detect late");
      step(2);
      chk(ci_ind === `LSEC_CI_LINK_SYNC && ci_ind_valid === 1'b1, "no sync code");
      $display("test lt detect done");
   endtask : t_lt_detect

   task automatic t_ones();
      int k;
      far_mode = 2'h2;
      wait_sig(1, 10 * FC);
      chk(n >= 8 * FC, "ones detect early");
      k = 0;
      grab();
      while (el !== LSEC_E_TREQ && k < 3) begin
         grab();
         k++;
      end
      chk(el === LSEC_E_TREQ && sw === `LSEC_BARKER, "no request");
      grab();
      chk(el === LSEC_E_PAYLOAD && nn == 36, "request not one frame");
      $display("test ones done");
   endtask : t_ones

   task automatic t_nt();
      cmd(LSEC_E_FRAMED_ZERO);
      grab();
      chk(el === LSEC_E_UNFRAMED_ZERO && sw === 11'h000, "unsynced framed");
      rx_locked = 1'b1;
      cmd(LSEC_E_FRAMED_ZERO);
      grab();
      chk(el === LSEC_E_FRAMED_ZERO && sw === `LSEC_BARKER, "synced framed zero");
      chk(ci_ind === `LSEC_CI_NONE && det_framed_zero === 1'b0, "nt zero seen");
      far_mode = 2'h2;
      wait_sig(2, 120);
      chk(n >= 78 && n <= 82, "request detect timing");
      cmd(LSEC_E_FRAMED_ONES);
      grab();
      chk(el === LSEC_E_PAYLOAD && transparent_ind === 1'b1, "not transparent");
      $display("test nt done");
   endtask : t_nt

   initial begin
      do_reset();
      t_silence_pulse();
      t_awake();
      t_framed();
      t_lt_detect();
      t_ones();
      lt_mode = 1'b0;
      far_mode = 2'h1;
      do_reset();
      t_nt();
      end_sim();
   end
endmodule : test_line_signal_element_codec

`default_nettype wire
